// ==== pkg/hpio_pkg.sv ====
package hpio_pkg;
	// Register byte addresses
	localparam logic [7:0] ADR_CONFIG  = 8'h00;
	localparam logic [7:0] ADR_PA_DIR  = 8'h04;
	localparam logic [7:0] ADR_PA_OUT  = 8'h08;
	localparam logic [7:0] ADR_PA_IN   = 8'h0C;
	localparam logic [7:0] ADR_PB_DIR  = 8'h10;
	localparam logic [7:0] ADR_PB_OUT  = 8'h14;
	localparam logic [7:0] ADR_PB_IN   = 8'h18;
	localparam logic [7:0] ADR_PC_DIR  = 8'h1C;
	localparam logic [7:0] ADR_PC_DATA = 8'h20;
	localparam logic [7:0] ADR_STATUS  = 8'h24;
	// Configuration fields
	localparam int CFG_MODE    = 0;
	localparam int CFG_PB_PORT = 1;
	localparam int CFG_PC_PORT = 2;
	localparam int CFG_DMA     = 3;
	localparam int CFG_EDGE1   = 4;
	localparam int CFG_EDGE2   = 5;
	localparam int CFG_W       = 6;
	// Port C data fields
	localparam int PC_IRQ2_BIT = 7;
	localparam int PC_IRQ1_BIT = 6;
	localparam int PC_IO_W     = 6;
	// Status fields
	localparam int ST_LAT1 = 0;
	localparam int ST_LAT2 = 1;
	// Reset values
	localparam logic [CFG_W-1:0] CONFIG_RST = 6'h00;
	localparam logic [7:0]       DIR_RST    = 8'h00;
	localparam logic [7:0]       OUT_RST    = 8'h00;
	// Synchroniser depth
	localparam int SYNC_STAGES = 2;
endpackage

// ==== design/hpio_sync.sv ====
`timescale 1ns/10ps
module hpio_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Data
	input  wire logic [W-1:0] async_in,
	input  wire logic [W-1:0] rst_val,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_d;

	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	// Reset to all ones: every synced pin is idle high or don't care
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_q   <= '1;
			sync_out <= '1;
		end else begin
			meta_q   <= meta_d;
			sync_out <= sync_d;
		end
	end
endmodule

// ==== design/hpio_port.sv ====
`timescale 1ns/10ps
module hpio_port #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Port function
	input  wire logic         alt_sel,
	input  wire logic [W-1:0] dir,
	input  wire logic [W-1:0] dout,
	// Alternate function
	input  wire logic [W-1:0] alt_out,
	input  wire logic [W-1:0] alt_oe,
	// Pin drive
	output logic      [W-1:0] pin_o,
	output logic      [W-1:0] pin_oe
);
	logic [W-1:0] pin_o_d;
	logic [W-1:0] pin_oe_d;

	// Each line picks its own direction in port function
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_comb begin
			pin_o_d[i]  = alt_sel ? alt_out[i] : dout[i];
			pin_oe_d[i] = alt_sel ? alt_oe[i] : dir[i];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_o  <= '0;
			pin_oe <= '0;
		end else begin
			pin_o  <= pin_o_d;
			pin_oe <= pin_oe_d;
		end
	end
endmodule

// ==== design/hpio_top.sv ====
`timescale 1ns/10ps
// Notes on behaviour
// - Emulation mode: port A pins carry host data bytes; otherwise plain port A.
// - Emulation mode: driver disable low while the host reads.
// - Host gives a three-bit address choosing the emulated register.
// - Emulation mode: host interrupt high while emulation interrupt pending.
// - Emulation mode with DMA: transmit ready low when holding register empty.
// - Emulation mode with DMA: receive ready low when a byte waits.
// - Mode 0: host control pins serve serial channel B signals instead.
// - Mode 0: each port A line individually input or output.
// - Port B: per-line direction in port function, else serial signals.
// - Port C bits five to zero individually input or output.
// - Port C bits seven, six read external interrupt two, one levels.
// - Edge capture: writing 1 to bit seven or six clears latch unless a falling edge sets it in the same cycle.
// - Configuration bit picks port C or serial A handshake on bits five-zero.
module hpio_top (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Host control pins, shared with serial B
	input  wire logic [2:0]  host_reg_address,
	input  wire logic        host_select_n,
	input  wire logic        host_write_n,
	input  wire logic        host_read_n,
	output logic             host_driver_disable_n,
	output logic             host_irq,
	output logic             host_tx_ready_n,
	output logic             host_rx_ready_n,
	// Port A pins, host_data_bus in emulation mode
	input  wire logic [7:0]  port_a_pins_i,
	output logic      [7:0]  port_a_pins_o,
	output logic      [7:0]  port_a_pins_oe,
	// Port B pins
	input  wire logic [7:0]  port_b_pins_i,
	output logic      [7:0]  port_b_pins_o,
	output logic      [7:0]  port_b_pins_oe,
	// Port C pins, bits five to zero
	input  wire logic [5:0]  port_c_pins_i,
	output logic      [5:0]  port_c_pins_o,
	output logic      [5:0]  port_c_pins_oe,
	// External interrupt pins
	input  wire logic        ext_irq_two_n,
	input  wire logic        ext_irq_one_n,
	// Emulation core side
	input  wire logic [7:0]  emu_rdata,
	input  wire logic        emu_irq_pending,
	input  wire logic        emu_thr_empty,
	input  wire logic        emu_rx_ready,
	output logic             emu_wr_strobe,
	output logic             emu_rd_strobe,
	output logic      [2:0]  emu_addr,
	output logic      [7:0]  emu_wdata,
	output logic             uart_emulation,
	// Serial B side
	input  wire logic        serial_b_tx_data,
	input  wire logic        serial_b_dtr_req_n,
	input  wire logic        serial_b_wait_request_n,
	input  wire logic        serial_b_rts_n,
	output logic             serial_b_rx_data,
	output logic             serial_b_sync_n,
	output logic             serial_b_clear_to_send_n,
	output logic             serial_b_carrier_detect_n,
	output logic             serial_b_trx_clk_n,
	output logic             serial_b_rtx_clk_n,
	// Port B alternate serial functions
	input  wire logic [7:0]  alt_b_out,
	input  wire logic [7:0]  alt_b_oe,
	output logic      [7:0]  alt_b_in,
	// Serial A handshake on port C
	input  wire logic [5:0]  serial_a_hs_out,
	input  wire logic [5:0]  serial_a_hs_oe,
	output logic      [5:0]  serial_a_hs_in
);
	localparam int SW = 30;

	logic [SW-1:0] sync_s;
	logic          irq2_s;
	logic          irq1_s;
	logic          cs_s;
	logic          rd_s;
	logic          wr_s;
	logic [2:0]    addr_s;
	logic [7:0]    pa_s;
	logic [7:0]    pb_s;
	logic [5:0]    pc_s;

	hpio_sync #(.W(SW)) u_sync (
		.clk      (clk),
		.rst      (rst),
		.async_in ({ext_irq_two_n, ext_irq_one_n, host_select_n, host_read_n, host_write_n,
		            host_reg_address, port_a_pins_i, port_b_pins_i, port_c_pins_i}),
		.rst_val  ({SW{1'b1}}),
		.sync_out (sync_s)
	);

	always_comb begin
		{irq2_s, irq1_s, cs_s, rd_s, wr_s, addr_s, pa_s, pb_s, pc_s} = sync_s;
	end

	// Register state
	logic [hpio_pkg::CFG_W-1:0] cfg_q, cfg_d;
	logic [7:0]  pa_dir_q, pa_dir_d, pa_out_q, pa_out_d;
	logic [7:0]  pb_dir_q, pb_dir_d, pb_out_q, pb_out_d;
	logic [5:0]  pc_dir_q, pc_dir_d, pc_out_q, pc_out_d;
	logic        lat1_q, lat1_d, lat2_q, lat2_d;
	logic        irq1_prev_q, irq2_prev_q;
	logic        ack_d;
	logic [31:0] rdat_d;
	logic        bus_req, bus_wr;
	logic        set1, set2, clr1, clr2;
	logic        mode;

	always_comb begin
		mode    = cfg_q[hpio_pkg::CFG_MODE];
		bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
		bus_wr  = bus_req && wb_we_i && wb_sel_i[0];
	end

	always_comb begin
		cfg_d    = cfg_q;
		pa_dir_d = pa_dir_q;
		pa_out_d = pa_out_q;
		pb_dir_d = pb_dir_q;
		pb_out_d = pb_out_q;
		pc_dir_d = pc_dir_q;
		pc_out_d = pc_out_q;
		ack_d    = bus_req;
		rdat_d   = '0;
		clr1     = 1'b0;
		clr2     = 1'b0;
		if (bus_wr) begin
			unique case (wb_adr_i)
				hpio_pkg::ADR_CONFIG:  cfg_d    = wb_dat_i[hpio_pkg::CFG_W-1:0];
				hpio_pkg::ADR_PA_DIR:  pa_dir_d = wb_dat_i[7:0];
				hpio_pkg::ADR_PA_OUT:  pa_out_d = wb_dat_i[7:0];
				hpio_pkg::ADR_PB_DIR:  pb_dir_d = wb_dat_i[7:0];
				hpio_pkg::ADR_PB_OUT:  pb_out_d = wb_dat_i[7:0];
				hpio_pkg::ADR_PC_DIR:  pc_dir_d = wb_dat_i[5:0];
				hpio_pkg::ADR_PC_DATA: begin
					pc_out_d = wb_dat_i[5:0];
					clr2     = wb_dat_i[hpio_pkg::PC_IRQ2_BIT];
					clr1     = wb_dat_i[hpio_pkg::PC_IRQ1_BIT];
				end
				default: ;
			endcase
		end
		if (bus_req && !wb_we_i) begin
			unique case (wb_adr_i)
				hpio_pkg::ADR_CONFIG:  rdat_d[hpio_pkg::CFG_W-1:0] = cfg_q;
				hpio_pkg::ADR_PA_DIR:  rdat_d[7:0] = pa_dir_q;
				hpio_pkg::ADR_PA_OUT:  rdat_d[7:0] = pa_out_q;
				hpio_pkg::ADR_PA_IN:   rdat_d[7:0] = pa_s;
				hpio_pkg::ADR_PB_DIR:  rdat_d[7:0] = pb_dir_q;
				hpio_pkg::ADR_PB_OUT:  rdat_d[7:0] = pb_out_q;
				hpio_pkg::ADR_PB_IN:   rdat_d[7:0] = pb_s;
				hpio_pkg::ADR_PC_DIR:  rdat_d[5:0] = pc_dir_q;
				hpio_pkg::ADR_PC_DATA: rdat_d[7:0] = {irq2_s, irq1_s, pc_s};
				hpio_pkg::ADR_STATUS:  rdat_d[1:0] = {lat2_q, lat1_q};
				default: ;
			endcase
		end
		// Falling edge sets the capture latch; a set beats a clear
		set1   = cfg_q[hpio_pkg::CFG_EDGE1] && irq1_prev_q && !irq1_s;
		set2   = cfg_q[hpio_pkg::CFG_EDGE2] && irq2_prev_q && !irq2_s;
		lat1_d = set1 || (lat1_q && !clr1);
		lat2_d = set2 || (lat2_q && !clr2);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_q       <= hpio_pkg::CONFIG_RST;
			pa_dir_q    <= hpio_pkg::DIR_RST;
			pa_out_q    <= hpio_pkg::OUT_RST;
			pb_dir_q    <= hpio_pkg::DIR_RST;
			pb_out_q    <= hpio_pkg::OUT_RST;
			pc_dir_q    <= hpio_pkg::DIR_RST[5:0];
			pc_out_q    <= hpio_pkg::OUT_RST[5:0];
			lat1_q      <= 1'b0;
			lat2_q      <= 1'b0;
			irq1_prev_q <= 1'b1;
			irq2_prev_q <= 1'b1;
			wb_ack_o    <= 1'b0;
			wb_dat_o    <= '0;
		end else begin
			cfg_q       <= cfg_d;
			pa_dir_q    <= pa_dir_d;
			pa_out_q    <= pa_out_d;
			pb_dir_q    <= pb_dir_d;
			pb_out_q    <= pb_out_d;
			pc_dir_q    <= pc_dir_d;
			pc_out_q    <= pc_out_d;
			lat1_q      <= lat1_d;
			lat2_q      <= lat2_d;
			irq1_prev_q <= irq1_s;
			irq2_prev_q <= irq2_s;
			wb_ack_o    <= ack_d;
			wb_dat_o    <= rdat_d;
		end
	end

	// Host access and pin sharing
	logic       rd_act, wr_act, rd_prev_q, wr_prev_q;
	logic       wr_stb_d, rd_stb_d;
	logic [2:0] addr_d;
	logic [7:0] wdata_d;
	logic       dd_d, hirq_d, txr_d, rxr_d;
	logic       sb_rx_d, sb_sync_d, sb_cts_d, sb_dcd_d, sb_trx_d, sb_rtx_d;
	logic       dma;

	always_comb begin
		dma      = cfg_q[hpio_pkg::CFG_DMA];
		rd_act   = mode && !cs_s && !rd_s;
		wr_act   = mode && !cs_s && !wr_s;
		wr_stb_d = wr_prev_q && !wr_act;
		rd_stb_d = rd_act && !rd_prev_q;
		addr_d   = (wr_act || rd_act) ? addr_s : emu_addr;
		wdata_d  = wr_act ? pa_s : emu_wdata;
		dd_d     = mode ? !rd_act : serial_b_tx_data;
		hirq_d   = mode ? emu_irq_pending : serial_b_dtr_req_n;
		txr_d    = mode ? !(dma && emu_thr_empty) : serial_b_wait_request_n;
		rxr_d    = mode ? !(dma && emu_rx_ready) : serial_b_rts_n;
		// Serial B inputs idle high while the host owns the pins
		sb_sync_d = mode || cs_s;
		sb_cts_d  = mode || wr_s;
		sb_dcd_d  = mode || rd_s;
		sb_trx_d  = mode || addr_s[0];
		sb_rx_d   = mode || addr_s[1];
		sb_rtx_d  = mode || addr_s[2];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_prev_q                 <= 1'b0;
			wr_prev_q                 <= 1'b0;
			emu_wr_strobe             <= 1'b0;
			emu_rd_strobe             <= 1'b0;
			emu_addr                  <= '0;
			emu_wdata                 <= '0;
			host_driver_disable_n     <= 1'b1;
			host_irq                  <= 1'b0;
			host_tx_ready_n           <= 1'b1;
			host_rx_ready_n           <= 1'b1;
			serial_b_rx_data          <= 1'b1;
			serial_b_sync_n           <= 1'b1;
			serial_b_clear_to_send_n  <= 1'b1;
			serial_b_carrier_detect_n <= 1'b1;
			serial_b_trx_clk_n        <= 1'b1;
			serial_b_rtx_clk_n        <= 1'b1;
			uart_emulation            <= 1'b0;
		end else begin
			rd_prev_q                 <= rd_act;
			wr_prev_q                 <= wr_act;
			emu_wr_strobe             <= wr_stb_d;
			emu_rd_strobe             <= rd_stb_d;
			emu_addr                  <= addr_d;
			emu_wdata                 <= wdata_d;
			host_driver_disable_n     <= dd_d;
			host_irq                  <= hirq_d;
			host_tx_ready_n           <= txr_d;
			host_rx_ready_n           <= rxr_d;
			serial_b_rx_data          <= sb_rx_d;
			serial_b_sync_n           <= sb_sync_d;
			serial_b_clear_to_send_n  <= sb_cts_d;
			serial_b_carrier_detect_n <= sb_dcd_d;
			serial_b_trx_clk_n        <= sb_trx_d;
			serial_b_rtx_clk_n        <= sb_rtx_d;
			uart_emulation            <= mode;
		end
	end

	always_comb begin
		alt_b_in       = pb_s;
		serial_a_hs_in = pc_s;
	end

	// Port A: host data while emulating, else per-line port
	hpio_port #(.W(8)) u_port_a (
		.clk     (clk),
		.rst     (rst),
		.alt_sel (mode),
		.dir     (pa_dir_q),
		.dout    (pa_out_q),
		.alt_out (emu_rdata),
		.alt_oe  ({8{rd_act}}),
		.pin_o   (port_a_pins_o),
		.pin_oe  (port_a_pins_oe)
	);

	hpio_port #(.W(8)) u_port_b (
		.clk     (clk),
		.rst     (rst),
		.alt_sel (!cfg_q[hpio_pkg::CFG_PB_PORT]),
		.dir     (pb_dir_q),
		.dout    (pb_out_q),
		.alt_out (alt_b_out),
		.alt_oe  (alt_b_oe),
		.pin_o   (port_b_pins_o),
		.pin_oe  (port_b_pins_oe)
	);

	hpio_port #(.W(hpio_pkg::PC_IO_W)) u_port_c (
		.clk     (clk),
		.rst     (rst),
		.alt_sel (!cfg_q[hpio_pkg::CFG_PC_PORT]),
		.dir     (pc_dir_q),
		.dout    (pc_out_q),
		.alt_out (serial_a_hs_out),
		.alt_oe  (serial_a_hs_oe),
		.pin_o   (port_c_pins_o),
		.pin_oe  (port_c_pins_oe)
	);

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_wr_end;
		wr_act ##1 !wr_act;
	endsequence

	sequence s_clr2_write;
		bus_wr && wb_adr_i == hpio_pkg::ADR_PC_DATA && wb_dat_i[hpio_pkg::PC_IRQ2_BIT] && !set2;
	endsequence

	a_dd_read_low: assert property (rd_act |=> !host_driver_disable_n)
		else $error("driver disable not low during host read");
	a_data_release: assert property (mode && $past(mode) && !$past(rd_act) |-> port_a_pins_oe == 8'h00)
		else $error("host data driven outside a read");
	a_data_drive: assert property (rd_act |=> port_a_pins_oe == 8'hFF && port_a_pins_o == $past(emu_rdata))
		else $error("host read data not driven");
	a_wr_pulse: assert property (s_wr_end |=> emu_wr_strobe ##1 !emu_wr_strobe)
		else $error("write strobe not a single pulse at end of write");
	a_wr_addr: assert property (emu_wr_strobe |-> emu_addr == $past(addr_s, 2))
		else $error("write address not the host address");
	a_irq_follow: assert property (mode && $past(mode) |-> host_irq == $past(emu_irq_pending))
		else $error("host interrupt does not follow pending");
	a_tx_ready: assert property (mode && dma && emu_thr_empty |=> !host_tx_ready_n)
		else $error("transmit ready not low");
	a_rx_ready: assert property (mode && !dma |=> host_rx_ready_n && host_tx_ready_n)
		else $error("ready outputs active without DMA");
	a_b_route: assert property (!mode |=> serial_b_sync_n == $past(cs_s) && host_driver_disable_n == $past(serial_b_tx_data))
		else $error("serial B routing wrong in mode 0");
	a_pa_dir: assert property (!mode |=> port_a_pins_oe == $past(pa_dir_q))
		else $error("port A direction not applied");
	a_latch_clear: assert property (s_clr2_write |=> !lat2_q)
		else $error("capture latch not cleared by write of one");
	a_latch_keep: assert property (lat2_q && !clr2 |=> lat2_q)
		else $error("capture latch lost without clear");
	a_bus_ack: assert property (bus_req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack not a single cycle");
endmodule

// ==== tb/hpio_host_model.sv ====
`timescale 1ns/10ps
module hpio_host_model (
	// Clock
	input  wire logic       clk,
	// Host data lines as resolved on the wire
	input  wire logic [7:0] data_in,
	// Host control
	output logic      [2:0] addr,
	output logic            sel_n,
	output logic            wr_n,
	output logic            rd_n,
	// Host data drive; released lines show the inverse of the last byte
	output logic      [7:0] d_o
);
	initial begin
		addr = 3'h0;
		sel_n = 1'b1;
		wr_n = 1'b1;
		rd_n = 1'b1;
		d_o = 8'hFF;
	end
	task automatic drive(input logic [7:0] v);
		d_o <= v;
	endtask
	task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		d_o <= d;
		sel_n <= 1'b0;
		wr_n <= 1'b0;
		repeat (4) @(posedge clk);
		wr_n <= 1'b1;
		// Address and data held past the synchroniser delay
		repeat (4) @(posedge clk);
		sel_n <= 1'b1;
		d_o <= ~d;
	endtask
	task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		sel_n <= 1'b0;
		rd_n <= 1'b0;
		repeat (6) @(posedge clk);
		d = data_in;
		rd_n <= 1'b1;
		repeat (4) @(posedge clk);
		sel_n <= 1'b1;
	endtask
endmodule

// ==== tb/hpio_top_tb.sv ====
`timescale 1ns/10ps
module hpio_top_tb;
	logic        clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, host_select_n, host_write_n, host_read_n;
	logic [7:0]  wb_adr_i, rd_v, hv, wa, wd, pa_ext, pb_ext, emu_rdata, emu_wdata, alt_b_out, alt_b_oe, alt_b_in;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [2:0]  host_reg_address, emu_addr;
	logic        host_driver_disable_n, host_irq, host_tx_ready_n, host_rx_ready_n, ext_irq_two_n, ext_irq_one_n;
	logic [7:0]  port_a_pins_i, port_a_pins_o, port_a_pins_oe, port_b_pins_i, port_b_pins_o, port_b_pins_oe;
	logic [5:0]  port_c_pins_i, port_c_pins_o, port_c_pins_oe, serial_a_hs_out, serial_a_hs_oe, serial_a_hs_in, pc_ext;
	logic        emu_irq_pending, emu_thr_empty, emu_rx_ready, emu_wr_strobe, emu_rd_strobe, uart_emulation;
	logic        serial_b_tx_data, serial_b_dtr_req_n, serial_b_wait_request_n, serial_b_rts_n, serial_b_rx_data;
	logic        serial_b_sync_n, serial_b_clear_to_send_n, serial_b_carrier_detect_n, serial_b_trx_clk_n;
	logic        serial_b_rtx_clk_n;
	int          err_total = 0, num_checks = 0, wr_cnt = 0, rd_cnt = 0, n0;
	// Wire levels from every party's drive
	assign port_a_pins_i = (port_a_pins_oe & port_a_pins_o) | (~port_a_pins_oe & pa_ext);
	assign port_b_pins_i = (port_b_pins_oe & port_b_pins_o) | (~port_b_pins_oe & pb_ext);
	assign port_c_pins_i = (port_c_pins_oe & port_c_pins_o) | (~port_c_pins_oe & pc_ext);
	hpio_top u_hpio_top (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
		.wb_ack_o, .host_reg_address, .host_select_n, .host_write_n, .host_read_n, .host_driver_disable_n, .host_irq,
		.host_tx_ready_n, .host_rx_ready_n, .port_a_pins_i, .port_a_pins_o, .port_a_pins_oe, .port_b_pins_i,
		.port_b_pins_o, .port_b_pins_oe, .port_c_pins_i, .port_c_pins_o, .port_c_pins_oe, .ext_irq_two_n,
		.ext_irq_one_n, .emu_rdata, .emu_irq_pending, .emu_thr_empty, .emu_rx_ready, .emu_wr_strobe, .emu_rd_strobe,
		.emu_addr, .emu_wdata, .uart_emulation, .serial_b_tx_data, .serial_b_dtr_req_n, .serial_b_wait_request_n,
		.serial_b_rts_n, .serial_b_rx_data, .serial_b_sync_n, .serial_b_clear_to_send_n, .serial_b_carrier_detect_n,
		.serial_b_trx_clk_n, .serial_b_rtx_clk_n, .alt_b_out, .alt_b_oe, .alt_b_in, .serial_a_hs_out,
		.serial_a_hs_oe, .serial_a_hs_in);
	hpio_host_model u_hpio_host_model (.clk, .data_in(port_a_pins_i), .addr(host_reg_address),
		.sel_n(host_select_n), .wr_n(host_write_n), .rd_n(host_read_n), .d_o(pa_ext));
	always #4 clk = ~clk;
	always @(posedge clk) begin
		if (emu_wr_strobe === 1'b1) begin
			wr_cnt <= wr_cnt + 1;
			wa <= {5'h00, emu_addr};
			wd <= emu_wdata;
		end
		if (emu_rd_strobe === 1'b1) begin
			rd_cnt <= rd_cnt + 1;
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic cy(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
		int n;
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= {24'h00_0000, d};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		rd_v = wb_dat_o[7:0];
		chk({31'h0000_0000, wb_ack_o}, 32'h0000_0001);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input int d);
		wb(1'b1, a, d[7:0], 4'h1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		wb(1'b0, a, 8'h00, 4'h1);
		chk(rd_v, e);
	endtask
	task automatic t_reset;
		rd(hpio_pkg::ADR_CONFIG, 8'h00);
		rd(hpio_pkg::ADR_PA_DIR, 8'h00);
		rd(hpio_pkg::ADR_PC_DIR, 8'h00);
		rd(hpio_pkg::ADR_STATUS, 8'h00);
		wb(1'b1, hpio_pkg::ADR_PA_DIR, 8'hFF, 4'h0);
		rd(hpio_pkg::ADR_PA_DIR, 8'h00);
		wr(8'hFC, 8'hFF);
		rd(8'hFC, 8'h00);
		chk(port_a_pins_oe, 8'h00);
	endtask
	task automatic t_pa;
		wr(hpio_pkg::ADR_PA_DIR, 8'h0F);
		wr(hpio_pkg::ADR_PA_OUT, 8'hA5);
		u_hpio_host_model.drive(8'h3C);
		cy(4);
		chk(port_a_pins_oe, 8'h0F);
		chk(port_a_pins_o & port_a_pins_oe, 8'h05);
		rd(hpio_pkg::ADR_PA_IN, 8'h35);
		wr(hpio_pkg::ADR_PA_DIR, 8'h00);
	endtask
	task automatic t_host;
		wr(hpio_pkg::ADR_CONFIG, 1 << hpio_pkg::CFG_MODE);
		cy(2);
		chk(uart_emulation, 1'b1);
		n0 = wr_cnt;
		u_hpio_host_model.bus_wr(3'h5, 8'hC6);
		cy(4);
		chk(wr_cnt - n0, 1);
		chk(wa, 8'h05);
		chk(wd, 8'hC6);
		chk(port_a_pins_oe, 8'h00);
		emu_rdata <= 8'h9B;
		n0 = rd_cnt;
		fork
			u_hpio_host_model.bus_rd(3'h2, hv);
			begin
				cy(6);
				chk(port_a_pins_oe, 8'hFF);
				chk(host_driver_disable_n, 1'b0);
			end
		join
		chk(hv, 8'h9B);
		chk(rd_cnt - n0, 1);
		cy(4);
		chk(port_a_pins_oe, 8'h00);
		chk(host_driver_disable_n, 1'b1);
	endtask
	task automatic t_irq;
		emu_irq_pending <= 1'b1;
		cy(3);
		chk(host_irq, 1'b1);
		chk(host_tx_ready_n, 1'b1);
		wr(hpio_pkg::ADR_CONFIG, (1 << hpio_pkg::CFG_MODE) | (1 << hpio_pkg::CFG_DMA));
		emu_thr_empty <= 1'b1;
		cy(3);
		chk(host_tx_ready_n, 1'b0);
		chk(host_rx_ready_n, 1'b1);
		emu_thr_empty <= 1'b0;
		emu_rx_ready <= 1'b1;
		emu_irq_pending <= 1'b0;
		cy(3);
		chk(host_tx_ready_n, 1'b1);
		chk(host_rx_ready_n, 1'b0);
		chk(host_irq, 1'b0);
	endtask
	task automatic t_serb;
		wr(hpio_pkg::ADR_CONFIG, 8'h00);
		serial_b_tx_data <= 1'b0;
		serial_b_rts_n <= 1'b0;
		serial_b_wait_request_n <= 1'b0;
		n0 = wr_cnt;
		fork
			u_hpio_host_model.bus_wr(3'h3, 8'h00);
			begin
				cy(6);
				chk(serial_b_sync_n, 1'b0);
				chk(serial_b_clear_to_send_n, 1'b0);
				chk({serial_b_rtx_clk_n, serial_b_rx_data, serial_b_trx_clk_n}, 3'h3);
				chk(host_driver_disable_n, 1'b0);
				chk(host_rx_ready_n, 1'b0);
				chk(host_tx_ready_n, 1'b0);
				chk(host_irq, 1'b1);
			end
		join
		cy(4);
		chk(wr_cnt - n0, 0);
		chk(serial_b_carrier_detect_n, 1'b1);
	endtask
	task automatic t_pb;
		wr(hpio_pkg::ADR_CONFIG, 1 << hpio_pkg::CFG_PB_PORT);
		wr(hpio_pkg::ADR_PB_DIR, 8'hF0);
		wr(hpio_pkg::ADR_PB_OUT, 8'h5A);
		pb_ext <= 8'h3C;
		cy(4);
		chk(port_b_pins_oe, 8'hF0);
		chk(port_b_pins_o & port_b_pins_oe, 8'h50);
		rd(hpio_pkg::ADR_PB_IN, 8'h5C);
		wr(hpio_pkg::ADR_CONFIG, 8'h00);
		alt_b_oe <= 8'h81;
		cy(4);
		chk(port_b_pins_oe, 8'h81);
		chk(alt_b_in, 8'hBD);
	endtask
	task automatic t_pc;
		wr(hpio_pkg::ADR_CONFIG, (1 << hpio_pkg::CFG_PC_PORT) | (1 << hpio_pkg::CFG_EDGE1) |
		   (1 << hpio_pkg::CFG_EDGE2));
		wr(hpio_pkg::ADR_PC_DIR, 8'h0F);
		wr(hpio_pkg::ADR_PC_DATA, 8'h15);
		pc_ext <= 6'h2A;
		ext_irq_one_n <= 1'b0;
		cy(5);
		chk(port_c_pins_oe, 6'h0F);
		chk(port_c_pins_o & port_c_pins_oe, 6'h05);
		rd(hpio_pkg::ADR_STATUS, 8'h01 << hpio_pkg::ST_LAT1);
		rd(hpio_pkg::ADR_PC_DATA, 8'hA5);
		// Second line falls: both latches set, bit seven now reads low
		ext_irq_two_n <= 1'b0;
		cy(4);
		rd(hpio_pkg::ADR_STATUS, 8'h03);
		rd(hpio_pkg::ADR_PC_DATA, 8'h25);
		wr(hpio_pkg::ADR_PC_DATA, 8'h00);
		rd(hpio_pkg::ADR_STATUS, 8'h03);
		wr(hpio_pkg::ADR_PC_DATA, 8'h01 << hpio_pkg::PC_IRQ1_BIT);
		rd(hpio_pkg::ADR_STATUS, 8'h01 << hpio_pkg::ST_LAT2);
		wr(hpio_pkg::ADR_PC_DATA, 8'h01 << hpio_pkg::PC_IRQ2_BIT);
		rd(hpio_pkg::ADR_STATUS, 8'h00);
		wr(hpio_pkg::ADR_CONFIG, 8'h00);
		serial_a_hs_oe <= 6'h2A;
		cy(4);
		chk(port_c_pins_oe, 6'h2A);
		chk(serial_a_hs_in, 6'h2A);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		{clk, rst, wb_cyc_i, wb_stb_i, wb_we_i} = 5'h08;
		{wb_adr_i, wb_sel_i, wb_dat_i} = 44'h000_0000_0000;
		{emu_rdata, emu_irq_pending, emu_thr_empty, emu_rx_ready, pb_ext, pc_ext} = 25'h000_0000;
		{ext_irq_two_n, ext_irq_one_n, serial_b_tx_data, serial_b_dtr_req_n} = 4'hF;
		{serial_b_wait_request_n, serial_b_rts_n} = 2'h3;
		{alt_b_out, alt_b_oe, serial_a_hs_out, serial_a_hs_oe} = {8'hFF, 8'h00, 6'h3F, 6'h00};
		cy(5);
		rst <= 1'b0;
		t_reset;
		t_pa;
		t_host;
		t_irq;
		t_serb;
		t_pb;
		t_pc;
		test_done;
	end
	initial begin
		cy(20000);
		err_total++;
		test_done;
	end
endmodule
